// ---- core/caops_pkg.sv ----
package caops_pkg;
	localparam int CAOPS_INSN_W = 14;
	localparam int CAOPS_DATA_W = 8;
	localparam int CAOPS_FADDR_W = 7;
	localparam int CAOPS_PC_W = 13;
	localparam int CAOPS_LIT_W = 11;
	// opcode fields of the 14-bit instruction word
	localparam logic [5:0] CAOPS_OPC_COMPL = 6'h09;
	localparam logic [5:0] CAOPS_OPC_DECR = 6'h03;
	localparam logic [5:0] CAOPS_OPC_INCR = 6'h0A;
	localparam logic [2:0] CAOPS_OPC_JUMP = 3'h5;
	localparam int CAOPS_AOP_HI = 13;
	localparam int CAOPS_AOP_LO = 8;
	localparam int CAOPS_JOP_HI = 13;
	localparam int CAOPS_JOP_LO = 11;
	localparam int CAOPS_DEST_BIT = 7;
	localparam int CAOPS_LATCH_HI = 4;
	localparam int CAOPS_LATCH_LO = 3;
	localparam logic [7:0] CAOPS_DATA_RST = 8'h00;
	localparam logic [12:0] CAOPS_PC_RST = 13'h0000;
	localparam logic [6:0] CAOPS_ADDR_RST = 7'h00;
	typedef enum logic [2:0] {
		CAOPS_ST_IDLE = 3'b001,
		CAOPS_ST_READ = 3'b010,
		CAOPS_ST_FLUSH = 3'b100
	} caops_state_t;
endpackage

// ---- core/caops_core.sv ----
`timescale 1ns/1ps
// Notes on behaviour
// RULE1: complement register, write to accumulator or register, zero flag
// RULE2: decrement register, choose destination, update zero flag
// RULE3: increment register, choose destination, update zero flag
// RULE4: branch literal loads program counter bits ten to zero
// RULE5: latch bits four, three fill counter bits twelve, eleven
// RULE6: branch takes two cycles, second executes nothing
// RULE7: zero flag from 8-bit wrapped result; branch keeps flags
module caops_core
	import caops_pkg::*;
#(
	parameter int DATA_W = CAOPS_DATA_W
) (
	input wire logic SYS_CLK,
	input wire logic RST_N,
	input wire logic INSN_VALID,
	input wire logic [CAOPS_INSN_W-1:0] INSN,
	input wire logic [DATA_W-1:0] PC_HIGH_LATCH,
	input wire logic [DATA_W-1:0] REG_RDATA,
	output logic INSN_READY,
	output logic [CAOPS_FADDR_W-1:0] REG_ADDR,
	output logic REG_RD,
	output logic REG_WR,
	output logic [DATA_W-1:0] REG_WDATA,
	output logic ACC_WR,
	output logic [DATA_W-1:0] ACC_WDATA,
	output logic ZERO_WR,
	output logic ZERO_FLAG,
	output logic PC_LOAD,
	output logic [CAOPS_PC_W-1:0] PC_TARGET,
	output logic FETCH_FLUSH
);
	localparam logic [1:0] OP_COM = 2'd0;
	localparam logic [1:0] OP_DEC = 2'd1;
	localparam logic [1:0] OP_INC = 2'd2;

	// sequencing group
	caops_state_t state_q, state_d;
	logic [1:0] op_q, op_d;
	logic dest_q, dest_d;
	logic [CAOPS_FADDR_W-1:0] addr_q, addr_d;
	logic ready_q, ready_d;
	logic rd_q, rd_d;
	// write-back group
	logic wr_q, wr_d;
	logic [DATA_W-1:0] wdata_q, wdata_d;
	logic acc_wr_q, acc_wr_d;
	logic [DATA_W-1:0] acc_q, acc_d;
	logic zwr_q, zwr_d;
	logic zero_q, zero_d;
	// branch group
	logic pcl_q, pcl_d;
	logic [CAOPS_PC_W-1:0] pct_q, pct_d;
	logic flush_q, flush_d;
	// decode of the offered word, shared by sequencer and branch group; ALU result for write-back
	logic take;
	logic is_jump;
	logic is_alu;
	logic [DATA_W-1:0] result;

	function automatic logic [DATA_W-1:0] alu_f(input logic [1:0] op, input logic [DATA_W-1:0] v);
		logic [DATA_W-1:0] r;
		r = ~v; // [RULE1]
		if (op == OP_DEC) begin
			r = v - DATA_W'(1); // [RULE2] [RULE7]
		end else if (op == OP_INC) begin
			r = v + DATA_W'(1); // [RULE3] [RULE7]
		end
		return r;
	endfunction

	function automatic logic is_jump_f(input logic [CAOPS_INSN_W-1:0] w);
		return w[CAOPS_JOP_HI:CAOPS_JOP_LO] == CAOPS_OPC_JUMP;
	endfunction

	function automatic logic is_alu_f(input logic [CAOPS_INSN_W-1:0] w);
		logic [5:0] f;
		f = w[CAOPS_AOP_HI:CAOPS_AOP_LO];
		return f == CAOPS_OPC_COMPL || f == CAOPS_OPC_DECR || f == CAOPS_OPC_INCR;
	endfunction

	function automatic logic [1:0] alu_code_f(input logic [CAOPS_INSN_W-1:0] w);
		logic [5:0] f;
		logic [1:0] c;
		f = w[CAOPS_AOP_HI:CAOPS_AOP_LO];
		c = OP_INC;
		if (f == CAOPS_OPC_COMPL) begin
			c = OP_COM;
		end else if (f == CAOPS_OPC_DECR) begin
			c = OP_DEC;
		end
		return c;
	endfunction

	// unknown opcodes are taken but start nothing, so ready stays high and fetch is not stalled
	assign take = INSN_VALID && ready_q && (state_q == CAOPS_ST_IDLE);
	assign is_jump = is_jump_f(INSN);
	assign is_alu = is_alu_f(INSN);

	always_comb begin
		state_d = state_q;
		op_d = op_q;
		dest_d = dest_q;
		addr_d = addr_q;
		ready_d = 1'b1;
		rd_d = 1'b0;
		case (state_q)
			CAOPS_ST_IDLE: begin
				if (take && is_jump) begin
					ready_d = 1'b0;
					state_d = CAOPS_ST_FLUSH; // [RULE6]
				end else if (take && is_alu) begin
					op_d = alu_code_f(INSN);
					dest_d = INSN[CAOPS_DEST_BIT];
					addr_d = INSN[CAOPS_FADDR_W-1:0];
					rd_d = 1'b1;
					ready_d = 1'b0;
					state_d = CAOPS_ST_READ;
				end
			end
			CAOPS_ST_READ: begin
				// write-back happens on this edge; a new word may be taken on the next
				state_d = CAOPS_ST_IDLE;
			end
			CAOPS_ST_FLUSH: begin
				// second branch cycle: ready was low, so the word offered now is not run
				state_d = CAOPS_ST_IDLE; // [RULE6]
			end
			default: begin
				state_d = CAOPS_ST_IDLE;
			end
		endcase
	end

	always_comb begin
		wr_d = 1'b0;
		wdata_d = wdata_q;
		acc_wr_d = 1'b0;
		acc_d = acc_q;
		zwr_d = 1'b0;
		zero_d = zero_q;
		result = alu_f(op_q, REG_RDATA);
		if (state_q == CAOPS_ST_READ) begin
			// read data stands only while the read strobe is high, so sample it here
			wdata_d = result;
			acc_d = result;
			wr_d = dest_q; // [RULE1] [RULE2] [RULE3]
			acc_wr_d = ~dest_q; // [RULE1] [RULE2] [RULE3]
			zwr_d = 1'b1;
			zero_d = (result == '0); // [RULE7]
		end
	end

	always_comb begin
		pcl_d = 1'b0;
		pct_d = pct_q;
		flush_d = 1'b0;
		if (take && is_jump) begin
			// flags untouched by the branch [RULE7]
			pct_d = {PC_HIGH_LATCH[CAOPS_LATCH_HI:CAOPS_LATCH_LO], INSN[CAOPS_LIT_W-1:0]}; // [RULE4] [RULE5]
			pcl_d = 1'b1;
			flush_d = 1'b1; // [RULE6]
		end
	end

	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			state_q <= CAOPS_ST_IDLE;
			op_q <= OP_COM;
			dest_q <= 1'b0;
			addr_q <= CAOPS_ADDR_RST;
			ready_q <= 1'b0;
			rd_q <= 1'b0;
		end else begin
			state_q <= state_d;
			op_q <= op_d;
			dest_q <= dest_d;
			addr_q <= addr_d;
			ready_q <= ready_d;
			rd_q <= rd_d;
		end
	end

	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			wr_q <= 1'b0;
			wdata_q <= CAOPS_DATA_RST;
			acc_wr_q <= 1'b0;
			acc_q <= CAOPS_DATA_RST;
			zwr_q <= 1'b0;
			zero_q <= 1'b0;
		end else begin
			wr_q <= wr_d;
			wdata_q <= wdata_d;
			acc_wr_q <= acc_wr_d;
			acc_q <= acc_d;
			zwr_q <= zwr_d;
			zero_q <= zero_d;
		end
	end

	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			pcl_q <= 1'b0;
			pct_q <= CAOPS_PC_RST;
			flush_q <= 1'b0;
		end else begin
			pcl_q <= pcl_d;
			pct_q <= pct_d;
			flush_q <= flush_d;
		end
	end

	assign INSN_READY = ready_q;
	assign REG_ADDR = addr_q;
	assign REG_RD = rd_q;
	assign REG_WR = wr_q;
	assign REG_WDATA = wdata_q;
	assign ACC_WR = acc_wr_q;
	assign ACC_WDATA = acc_q;
	assign ZERO_WR = zwr_q;
	assign ZERO_FLAG = zero_q;
	assign PC_LOAD = pcl_q;
	assign PC_TARGET = pct_q;
	assign FETCH_FLUSH = flush_q;
endmodule

// ---- test/caops_regfile_mdl.sv ----
`timescale 1ns/1ps
module caops_regfile_mdl (
	input logic clk,
	input logic rd,
	input logic wr,
	input logic [6:0] addr,
	input logic [7:0] wdata,
	output logic [7:0] rdata
);
	logic [7:0] mem [128];
	// inverse when idle, so a late sample cannot match by luck
	assign rdata = rd ? mem[addr] : ~mem[addr];
	always @(posedge clk) if (wr) mem[addr] <= wdata;
endmodule

// ---- test/caops_chk.sv ----
`timescale 1ns/1ps
module caops_chk
	import caops_pkg::*;
(
	input logic SYS_CLK,
	input logic RST_N,
	input logic INSN_VALID,
	input logic INSN_READY,
	input logic [13:0] INSN,
	input logic [7:0] PC_HIGH_LATCH,
	input logic [7:0] REG_RDATA,
	input logic REG_WR,
	input logic [7:0] REG_WDATA,
	input logic ACC_WR,
	input logic [7:0] ACC_WDATA,
	input logic ZERO_WR,
	input logic ZERO_FLAG,
	input logic PC_LOAD,
	input logic [12:0] PC_TARGET,
	input logic REG_RD,
	input logic [6:0] REG_ADDR,
	input logic FETCH_FLUSH
);
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (!RST_N);
	wire tk = INSN_VALID && INSN_READY;
	wire jp = tk && INSN[13:11] == CAOPS_OPC_JUMP;
	wire [5:0] op = INSN[13:8];
	wire [7:0] r = ACC_WR ? ACC_WDATA : REG_WDATA;
	wire al = tk && (op == CAOPS_OPC_COMPL || op == CAOPS_OPC_DECR || op == CAOPS_OPC_INCR);
	a_comp_res: assert property (tk && op == CAOPS_OPC_COMPL |-> ##2 r == ~$past(REG_RDATA)
		&& REG_WR == $past(INSN[7], 2)) else $error("comp");
	a_dec_res: assert property (tk && op == CAOPS_OPC_DECR |-> ##2 r == $past(REG_RDATA) - 8'h01
		&& REG_WR == $past(INSN[7], 2)) else $error("dec");
	a_inc_res: assert property (tk && op == CAOPS_OPC_INCR |-> ##2 r == $past(REG_RDATA) + 8'h01
		&& REG_WR == $past(INSN[7], 2)) else $error("inc");
	a_read_addr: assert property (al |=> REG_RD && REG_ADDR == $past(INSN[6:0])) else $error("read");
	a_zero_res: assert property (ZERO_WR |-> ZERO_FLAG == (r == 8'h00) && ACC_WR != REG_WR) else $error("zero");
	a_jump_low: assert property (jp |=> PC_LOAD && PC_TARGET[10:0] == $past(INSN[10:0])) else $error("low");
	a_jump_high: assert property (PC_LOAD |-> PC_TARGET[12:11] == $past(PC_HIGH_LATCH[4:3])
		&& $stable(ZERO_FLAG)) else $error("high");
	a_jump_wait: assert property (jp |=> !INSN_READY ##1 INSN_READY) else $error("wait");
	a_flush_pulse: assert property (jp |=> FETCH_FLUSH ##1 !FETCH_FLUSH && !REG_RD) else $error("flush");
	cover property (jp);
	cover property (ZERO_WR && ZERO_FLAG);
	cover property (REG_WR);
endmodule
bind caops_core caops_chk chk_u (
	.SYS_CLK(SYS_CLK),
	.RST_N(RST_N),
	.INSN_VALID(INSN_VALID),
	.INSN_READY(INSN_READY),
	.INSN(INSN),
	.PC_HIGH_LATCH(PC_HIGH_LATCH),
	.REG_RDATA(REG_RDATA),
	.REG_WR(REG_WR),
	.REG_WDATA(REG_WDATA),
	.ACC_WR(ACC_WR),
	.ACC_WDATA(ACC_WDATA),
	.ZERO_WR(ZERO_WR),
	.ZERO_FLAG(ZERO_FLAG),
	.PC_LOAD(PC_LOAD),
	.PC_TARGET(PC_TARGET),
	.REG_RD(REG_RD),
	.REG_ADDR(REG_ADDR),
	.FETCH_FLUSH(FETCH_FLUSH)
);

// ---- test/tb_core_alu_branch_ops.sv ----
`timescale 1ns/1ps
module tb_core_alu_branch_ops;
	import caops_pkg::*;
	logic clk = 0, rst_n = 0, vld = 0, rdy, rd, rw, aw, zw, zf, pl, ff;
	logic [13:0] insn = 14'h0000;
	logic [7:0] lat = 8'h00, rdat, wd, ad;
	logic [6:0] a;
	logic [12:0] pt;
	int err_count = 0, n_compared = 0, cyc = 0;
	caops_core dut_u (.SYS_CLK(clk), .RST_N(rst_n), .INSN_VALID(vld), .INSN(insn), .PC_HIGH_LATCH(lat),
		.REG_RDATA(rdat), .INSN_READY(rdy), .REG_ADDR(a), .REG_RD(rd), .REG_WR(rw), .REG_WDATA(wd), .ACC_WR(aw),
		.ACC_WDATA(ad), .ZERO_WR(zw), .ZERO_FLAG(zf), .PC_LOAD(pl), .PC_TARGET(pt), .FETCH_FLUSH(ff));
	caops_regfile_mdl mdl_u (.clk(clk), .rd(rd), .wr(rw), .addr(a), .wdata(wd), .rdata(rdat));
	initial forever #2 clk = ~clk;
	function logic [7:0] alu(int k, logic [7:0] v);
		return k == 0 ? ~v : k == 1 ? v - 8'h01 : v + 8'h01;
	endfunction
	task chk(string s, logic [31:0] e, logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			err_count++;
			$display("mismatch %s exp %h got %h", s, e, g);
		end
	endtask
	task report_and_stop;
		$display("compared %0d errors %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	always @(posedge clk) if (++cyc == 3000) begin
		err_count++;
		report_and_stop;
	end
	initial begin
		logic [7:0] v, e;
		logic d, z;
		int k;
		void'($urandom(42207));
		repeat (8) @(negedge clk);
		chk("reset", 32'h0000_0000, {rdy, rd, rw, aw, zw, zf, pl, ff, pt, a});
		rst_n = 1;
		for (int j = 0; j < 300; j++) begin
			if (j == 150) begin
				// second reset between instructions; every output clears at once
				rst_n = 0;
				@(negedge clk);
				chk("reset", 32'h0000_0000, {rdy, rd, rw, aw, zw, zf, pl, ff, pt, a});
				rst_n = 1;
			end
			// first dozen pair every op with 00, ff and 01 to hit the zero edges
			k = j < 12 ? j % 4 : $urandom % 4;
			v = j >= 12 ? 8'($urandom) : j % 3 == 2 ? 8'h01 : {8{j % 3 == 1}};
			d = 1'($urandom);
			lat = 8'($urandom);
			z = zf;
			insn = k == 3 ? {CAOPS_OPC_JUMP, 11'($urandom)} :
				{k == 0 ? CAOPS_OPC_COMPL : k == 1 ? CAOPS_OPC_DECR : CAOPS_OPC_INCR, d, 7'($urandom)};
			mdl_u.mem[insn[6:0]] = v;
			vld = 1;
			while (!rdy) @(negedge clk);
			@(negedge clk);
			vld = 0;
			if (k == 3) begin
				chk("jump", {3'b110, z, lat[4:3], insn[10:0]}, {pl, ff, rdy, zf, pt});
				@(negedge clk);
				chk("hold", 32'h0000_0001, {pl, ff, rd, rdy});
			end else begin
				chk("read", {2'b10, insn[6:0]}, {rd, rdy, a});
				@(negedge clk);
				e = alu(k, v);
				chk("alu", {d, !d, 1'b1, e == 8'h00, 1'b1, e}, {rw, aw, zw, zf, rdy, d ? wd : ad});
			end
			@(negedge clk);
		end
		report_and_stop;
	end
endmodule
